// *** rtl/rtcac_pkg.sv ***
// package: map, fields, resets and timing of the calendar clock
`default_nettype none
package rtcac_pkg;
    // register byte offsets
    localparam logic [7:0] OFS_SUB_COUNT  = 8'h00;
    localparam logic [7:0] OFS_SECOND     = 8'h04;
    localparam logic [7:0] OFS_MINUTE     = 8'h08;
    localparam logic [7:0] OFS_HOUR       = 8'h0c;
    localparam logic [7:0] OFS_WEEKDAY    = 8'h10;
    localparam logic [7:0] OFS_DAY        = 8'h14;
    localparam logic [7:0] OFS_MONTH      = 8'h18;
    localparam logic [7:0] OFS_YEAR       = 8'h1c;
    localparam logic [7:0] OFS_ALM_SECOND = 8'h20;
    localparam logic [7:0] OFS_ALM_MONTH  = 8'h34;
    localparam logic [7:0] OFS_CTRL_ONE   = 8'h38;
    localparam logic [7:0] OFS_CTRL_TWO   = 8'h3c;
    localparam int         NUM_ALARMS     = 6;
    // clock_control_one fields
    localparam int CR1_CARRY_FLAG   = 7;
    localparam int CR1_CARRY_IRQ_EN = 4;
    localparam int CR1_ALARM_IRQ_EN = 3;
    localparam int CR1_ALARM_FLAG   = 0;
    // clock_control_two fields
    localparam int CR2_PERIODIC_FLAG = 7;
    localparam int CR2_PSEL_LSB      = 4;
    localparam int CR2_OSC_EN        = 3;
    localparam int CR2_DIV_RESET     = 1;
    localparam int CR2_START         = 0;
    // alarm field enable above the value
    localparam int ALARM_ENABLE_BIT  = 7;
    // reset values
    localparam logic [7:0]  CR1_RESET   = 8'h00;
    localparam logic [2:0]  PSEL_RESET  = 3'h0;
    localparam logic        OSC_RESET   = 1'b1;
    localparam logic        START_RESET = 1'b1;
    localparam logic [7:0]  DAY_RESET   = 8'h01;
    localparam logic [7:0]  MONTH_RESET = 8'h01;
    localparam logic [15:0] YEAR_RESET  = 16'h0000;
    // timing: 10 mhz cycles in one 1/256 s tick
    localparam int TICK256_CYCLES  = 39062;
    // axi responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // write channel states
    typedef enum logic [1:0] {
        WR_COLLECT = 2'b01,
        WR_RESPOND = 2'b10
    } rtcac_wr_e;
    // calendar time, binary coded
    typedef struct packed {
        logic [15:0] year;
        logic [7:0]  month;
        logic [7:0]  day;
        logic [7:0]  weekday;
        logic [7:0]  hour;
        logic [7:0]  minute;
        logic [7:0]  second;
    } rtcac_time_s;
endpackage
`default_nettype wire

// *** rtl/rtcac_top.sv ***
// module: calendar clock with alarm, periodic and carry requests
//
// Function
// (RQ1) stop, load all counters, restart
// (RQ2) carry during write updates written data
// (RQ3) recheck carry flag, repeat write
// (RQ4) carry during read forces reread
// (RQ5) carry seen by polling flag or interrupt
// (RQ6) alarm on any combination of six fields
// (RQ7) field enable bit selects compared fields
// (RQ8) all enabled fields match sets alarm flag
// (RQ9) alarm flag persists through match
// (RQ10) alarm request equals flag and enable
// (RQ11) periodic request when select nonzero and flag
// (RQ12) carry request equals carry flag and enable
// (RQ13) init: control one, divider reset, rest
// (RQ14) select codes give 1/256 to 2 seconds
// (RQ15) divider reset clears prescaler, self clears
// (RQ16) alarm flag cleared by zero, one ignored
// (RQ17) start halts calendar, not sub counter
// (RQ18) carry during counter access sets sticky flag
// (RQ19) requests are levels following flag and enable
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`default_nettype none
module rtcac_top
#(
    parameter int TICK_CYCLES = rtcac_pkg::TICK256_CYCLES
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // axi4-lite write
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    output logic [1:0]       s_axi_bresp,
    // axi4-lite read
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    input  wire logic [7:0]  s_axi_araddr,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    // interrupt requests
    output logic             alarm_request,
    output logic             periodic_request,
    output logic             carry_request
);
    import rtcac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // functions

    // days in a month; every fourth year is a leap year
    function automatic logic [7:0] month_days(input logic [7:0] m, input logic [15:0] y);
        case (m)
            8'h02:                      month_days = (y[1:0] == 2'h0) ? 8'h1d : 8'h1c;
            8'h04, 8'h06, 8'h09, 8'h0b: month_days = 8'h1e;
            default:                    month_days = 8'h1f;
        endcase
    endfunction

    // one second forward, cascading up to the year
    function automatic rtcac_time_s add_second(input rtcac_time_s t);
        rtcac_time_s r;
        r = t;
        r.second = t.second + 8'h01;
        if (t.second >= 8'h3b) begin
            r.second = 8'h00;
            r.minute = t.minute + 8'h01;
            if (t.minute >= 8'h3b) begin
                r.minute = 8'h00;
                r.hour   = t.hour + 8'h01;
                if (t.hour >= 8'h17) begin
                    r.hour    = 8'h00;
                    r.weekday = (t.weekday >= 8'h06) ? 8'h00 : t.weekday + 8'h01;
                    r.day     = t.day + 8'h01;
                    if (t.day >= month_days(t.month, t.year)) begin
                        r.day   = 8'h01;
                        r.month = t.month + 8'h01;
                        if (t.month >= 8'h0c) begin
                            r.month = 8'h01;
                            r.year  = t.year + 16'h0001;
                        end
                    end
                end
            end
        end
        return r;
    endfunction

    // periodic event from the 256 hz sub counter
    function automatic logic periodic_hit(input logic [2:0] sel, input logic [7:0] sub,
                                          input logic two);
        case (sel)
            3'h1:    periodic_hit = 1'b1;
            3'h2:    periodic_hit = (sub[1:0] == 2'h3);
            3'h3:    periodic_hit = (sub[3:0] == 4'hf);
            3'h4:    periodic_hit = (sub[5:0] == 6'h3f);
            3'h5:    periodic_hit = (sub[6:0] == 7'h7f);
            3'h6:    periodic_hit = (sub == 8'hff);
            3'h7:    periodic_hit = (sub == 8'hff) && two;
            default: periodic_hit = 1'b0;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // state

    rtcac_wr_e   wr_state_q, wr_state_d;
    logic        aw_have_q, aw_have_d, w_have_q, w_have_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] presc_q, presc_d;
    logic [7:0]  sub_q, sub_d;
    logic        two_q, two_d;
    rtcac_time_s time_q, time_d;
    logic [7:0]  alarm_q [NUM_ALARMS];
    logic [7:0]  alarm_d [NUM_ALARMS];
    logic        cf_q, cf_d, cie_q, cie_d, aie_q, aie_d, af_q, af_d;
    logic        pef_q, pef_d, osc_q, osc_d, start_q, start_d;
    logic [2:0]  psel_q, psel_d;
    logic        access_q, access_d;

    logic        do_wr, do_rd, tick256, carry, match;
    logic [5:0]  wr_idx, rd_idx;
    logic [7:0]  wbyte;
    logic [5:0]  alarm_en_vec;
    logic [47:0] alarm_cmp;

    ////////////////////////////////////////////////////////////////////////////
    // bus handshakes and decode

    // a write happens once address and data are both held
    assign do_wr         = aw_have_q && w_have_q && (wr_state_q == WR_COLLECT);
    assign do_rd         = s_axi_arvalid && !rvalid_q;
    assign s_axi_awready = !aw_have_q && (wr_state_q == WR_COLLECT);
    assign s_axi_wready  = !w_have_q && (wr_state_q == WR_COLLECT);
    assign s_axi_arready = !rvalid_q;
    assign s_axi_bvalid  = (wr_state_q == WR_RESPOND);
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign wr_idx        = awaddr_q[7:2];
    assign rd_idx        = s_axi_araddr[7:2];
    assign wbyte         = wstrb_q[0] ? wdata_q[7:0] : 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // divider, alarm compare and requests

    // prescaler runs only with the oscillator on
    assign tick256 = osc_q && (presc_q == 32'(TICK_CYCLES - 1)); // RQ17
    // calendar advances only while started
    assign carry   = tick256 && (sub_q == 8'hff) && start_q; // RQ17
    assign alarm_cmp = {time_q.month, time_q.day, time_q.weekday,
                        time_q.hour, time_q.minute, time_q.second};

    // disabled fields always match; none enabled means no match
    always_comb begin
        match = 1'b1;
        for (int i = 0; i < NUM_ALARMS; i++) begin
            alarm_en_vec[i] = alarm_q[i][ALARM_ENABLE_BIT];
            if (alarm_q[i][ALARM_ENABLE_BIT] &&
                (alarm_q[i][6:0] != alarm_cmp[8*i +: 7])) begin // RQ7
                match = 1'b0;
            end
        end
        match = match && (alarm_en_vec != 6'h00); // RQ6
    end

    // requests are levels of flag and enable
    assign alarm_request    = af_q && aie_q; // RQ10 RQ19
    assign periodic_request = (psel_q != 3'h0) && pef_q; // RQ11 RQ19
    assign carry_request    = cf_q && cie_q; // RQ12 RQ19 RQ5

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        rtcac_time_s t;
        logic        div_clr;
        t          = time_q;
        div_clr    = 1'b0;
        wr_state_d = wr_state_q;
        aw_have_d  = aw_have_q;
        w_have_d   = w_have_q;
        awaddr_d   = awaddr_q;
        wdata_d    = wdata_q;
        wstrb_d    = wstrb_q;
        bresp_d    = bresp_q;
        rvalid_d   = rvalid_q;
        rdata_d    = rdata_q;
        rresp_d    = rresp_q;
        alarm_d    = alarm_q;
        cie_d      = cie_q;
        aie_d      = aie_q;
        osc_d      = osc_q;
        start_d    = start_q;
        psel_d     = psel_q;
        access_d   = access_q;
        cf_d       = cf_q;
        af_d       = af_q;
        pef_d      = pef_q;
        // channel capture, either order
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_d = 1'b1;
            awaddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_d = 1'b1;
            wdata_d  = s_axi_wdata;
            wstrb_d  = s_axi_wstrb;
        end
        if (wr_state_q == WR_RESPOND && s_axi_bready) begin
            wr_state_d = WR_COLLECT;
        end
        // register writes
        if (do_wr) begin
            aw_have_d  = 1'b0;
            w_have_d   = 1'b0;
            wr_state_d = WR_RESPOND;
            bresp_d    = (awaddr_q <= OFS_CTRL_TWO) ? RESP_OKAY : RESP_SLVERR;
            if (wr_idx >= OFS_SECOND[7:2] && wr_idx <= OFS_YEAR[7:2]) begin
                access_d = 1'b1;
            end
            if (wstrb_q[0]) begin
                case (awaddr_q)
                    OFS_SECOND:  t.second  = wbyte;
                    OFS_MINUTE:  t.minute  = wbyte;
                    OFS_HOUR:    t.hour    = wbyte;
                    OFS_WEEKDAY: t.weekday = wbyte;
                    OFS_DAY:     t.day     = wbyte;
                    OFS_MONTH:   t.month   = wbyte;
                    OFS_CTRL_ONE: begin
                        cie_d    = wbyte[CR1_CARRY_IRQ_EN];
                        aie_d    = wbyte[CR1_ALARM_IRQ_EN];
                        access_d = 1'b0; // new access window starts here
                        if (!wbyte[CR1_CARRY_FLAG]) cf_d = 1'b0;
                        if (!wbyte[CR1_ALARM_FLAG]) af_d = 1'b0; // RQ16
                    end
                    OFS_CTRL_TWO: begin
                        pef_d   = wbyte[CR2_PERIODIC_FLAG];
                        psel_d  = wbyte[CR2_PSEL_LSB +: 3];
                        osc_d   = wbyte[CR2_OSC_EN];
                        start_d = wbyte[CR2_START];
                        div_clr = wbyte[CR2_DIV_RESET]; // RQ15
                    end
                    default: begin
                        if (awaddr_q >= OFS_ALM_SECOND && awaddr_q <= OFS_ALM_MONTH) begin
                            alarm_d[3'(wr_idx - OFS_ALM_SECOND[7:2])] = wbyte; // RQ7
                        end
                    end
                endcase
            end
            if (awaddr_q == OFS_YEAR) begin
                if (wstrb_q[0]) t.year[7:0]  = wdata_q[7:0];
                if (wstrb_q[1]) t.year[15:8] = wdata_q[15:8];
            end
        end
        // a carry in the write cycle lands on the written data
        time_d = carry ? add_second(t) : t; // RQ2
        // divider chain; the clear bit is not stored
        presc_d = (div_clr || tick256) ? 32'h0 : (osc_q ? presc_q + 32'h1 : presc_q); // RQ15
        sub_d   = div_clr ? 8'h00 : (tick256 ? sub_q + 8'h01 : sub_q); // RQ17
        two_d   = div_clr ? 1'b0 : ((tick256 && sub_q == 8'hff) ? !two_q : two_q);
        // reads
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (do_rd) begin
            rvalid_d = 1'b1;
            rresp_d  = (s_axi_araddr <= OFS_CTRL_TWO) ? RESP_OKAY : RESP_SLVERR;
            if (rd_idx <= OFS_YEAR[7:2]) begin
                access_d = 1'b1;
            end
            case (s_axi_araddr)
                OFS_SUB_COUNT: rdata_d = {25'h0, sub_q[7:1]};
                OFS_SECOND:    rdata_d = {24'h0, time_q.second};
                OFS_MINUTE:    rdata_d = {24'h0, time_q.minute};
                OFS_HOUR:      rdata_d = {24'h0, time_q.hour};
                OFS_WEEKDAY:   rdata_d = {24'h0, time_q.weekday};
                OFS_DAY:       rdata_d = {24'h0, time_q.day};
                OFS_MONTH:     rdata_d = {24'h0, time_q.month};
                OFS_YEAR:      rdata_d = {16'h0, time_q.year};
                OFS_CTRL_ONE:  rdata_d = {24'h0, cf_q, 2'h0, cie_q, aie_q, 2'h0, af_q};
                OFS_CTRL_TWO:  rdata_d = {24'h0, pef_q, psel_q, osc_q, 2'h0, start_q};
                default: begin
                    rdata_d = 32'h0;
                    if (s_axi_araddr >= OFS_ALM_SECOND && s_axi_araddr <= OFS_ALM_MONTH) begin
                        rdata_d = {24'h0, alarm_q[3'(rd_idx - OFS_ALM_SECOND[7:2])]};
                    end
                end
            endcase
        end
        // hardware sets win over software clears
        if (carry && (access_q || access_d)) cf_d = 1'b1; // RQ18
        if (match) af_d = 1'b1; // RQ8 RQ9
        if (tick256 && periodic_hit(psel_q, sub_q, two_q)) pef_d = 1'b1; // RQ14
    end

    ////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_state_q <= WR_COLLECT;
            aw_have_q  <= 1'b0;
            w_have_q   <= 1'b0;
            awaddr_q   <= 8'h00;
            wdata_q    <= 32'h0;
            wstrb_q    <= 4'h0;
            bresp_q    <= RESP_OKAY;
            rvalid_q   <= 1'b0;
            rdata_q    <= 32'h0;
            rresp_q    <= RESP_OKAY;
            presc_q    <= 32'h0;
            sub_q      <= 8'h00;
            two_q      <= 1'b0;
            time_q     <= '{year: YEAR_RESET, month: MONTH_RESET, day: DAY_RESET,
                            default: 8'h00};
            for (int i = 0; i < NUM_ALARMS; i++) alarm_q[i] <= 8'h00;
            cf_q       <= CR1_RESET[CR1_CARRY_FLAG];
            cie_q      <= CR1_RESET[CR1_CARRY_IRQ_EN];
            aie_q      <= CR1_RESET[CR1_ALARM_IRQ_EN];
            af_q       <= CR1_RESET[CR1_ALARM_FLAG];
            pef_q      <= 1'b0;
            psel_q     <= PSEL_RESET;
            osc_q      <= OSC_RESET;
            start_q    <= START_RESET;
            access_q   <= 1'b0;
        end else begin
            wr_state_q <= wr_state_d;
            aw_have_q  <= aw_have_d;
            w_have_q   <= w_have_d;
            awaddr_q   <= awaddr_d;
            wdata_q    <= wdata_d;
            wstrb_q    <= wstrb_d;
            bresp_q    <= bresp_d;
            rvalid_q   <= rvalid_d;
            rdata_q    <= rdata_d;
            rresp_q    <= rresp_d;
            presc_q    <= presc_d;
            sub_q      <= sub_d;
            two_q      <= two_d;
            time_q     <= time_d;
            alarm_q    <= alarm_d;
            cf_q       <= cf_d;
            cie_q      <= cie_d;
            aie_q      <= aie_d;
            af_q       <= af_d;
            pef_q      <= pef_d;
            psel_q     <= psel_d;
            osc_q      <= osc_d;
            start_q    <= start_d;
            access_q   <= access_d;
        end
    end
endmodule
`default_nettype wire

// *** tb/rtcac_checker.sv ***
// checker: bus and request properties of the calendar clock
`default_nettype none
module rtcac_checker
    import rtcac_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        reset,
    // axi4-lite write
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0]  s_axi_wstrb,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    // axi4-lite read
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    // interrupt requests
    input wire logic        alarm_request,
    input wire logic        periodic_request,
    input wire logic        carry_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // byte write with address and data taken at one edge
    logic wr_both;
    assign wr_both = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
                     && s_axi_wstrb[0];
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_quiet: assert property ($fell(reset) |-> !s_axi_bvalid && !s_axi_rvalid
        && !alarm_request && !periodic_request && !carry_request)
        else $error("outputs not idle after reset");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr >= 8'h40
        |=> s_axi_rvalid && s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_unmapped_wr: assert property (wr_both && s_axi_awaddr >= 8'h40
        |=> ##1 s_axi_bvalid && s_axi_bresp == RESP_SLVERR)
        else $error("unmapped write not refused");
    a_div_self_clr: assert property (s_axi_arvalid && s_axi_arready
        && s_axi_araddr == OFS_CTRL_TWO |=> !s_axi_rdata[CR2_DIV_RESET])
        else $error("divider reset bit reads one");
    a_carry_req_off: assert property (wr_both && s_axi_awaddr == OFS_CTRL_ONE
        && !s_axi_wdata[CR1_CARRY_IRQ_EN] |=> ##1 !carry_request [*2])
        else $error("carry request with enable off");
    a_alarm_req_off: assert property (wr_both && s_axi_awaddr == OFS_CTRL_ONE
        && !s_axi_wdata[CR1_ALARM_IRQ_EN] |=> ##1 !alarm_request [*2])
        else $error("alarm request with enable off");
    a_psel_zero: assert property (wr_both && s_axi_awaddr == OFS_CTRL_TWO
        && s_axi_wdata[CR2_PSEL_LSB +: 3] == 3'h0 |=> ##1 !periodic_request [*2])
        else $error("periodic request with select zero");
    // each request seen rising
    c_alarm: cover property ($rose(alarm_request));
    c_carry: cover property ($rose(carry_request));
    c_periodic: cover property ($rose(periodic_request));
endmodule
bind rtcac_top rtcac_checker i_rtcac_checker (.*);
`default_nettype wire

// *** tb/tb.sv ***
// testbench: bus, alarm, periodic, carry and divider checks
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import rtcac_pkg::*;
    localparam int TK = 4; // short tick: a second is 1024 cycles
    localparam int SEC = 256 * TK;
    logic clk = 0, reset = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic alarm_request, periodic_request, carry_request;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    int n_fail = 0, n_tests = 0, cyc = 0, seed = 91;
    rtcac_top #(.TICK_CYCLES(TK)) i_rtcac_top (.*);
    // clock and watchdog
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            wrap_up();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // bus tasks start at an edge: no signal driven twice in a step
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        bit aw_ok, w_ok;
        aw_ok = 0;
        w_ok = 0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(aw_ok && w_ok)) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge clk); while (!s_axi_bvalid);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (!s_axi_rvalid);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] rs;
        wr(a, d, rs);
        chk("write response", 32'(RESP_OKAY), 32'(rs));
    endtask
    task automatic r(input string nm, input logic [7:0] a, input logic [31:0] mk,
                     input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] rs;
        rd(a, d, rs);
        chk(nm, e, d & mk);
    endtask
    task automatic wait_pr(output int t);
        do begin
            @(posedge clk);
            #1;
        end while (!periodic_request);
        t = cyc;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] d0, d1;
        logic [1:0] rs;
        logic [7:0] s, m;
        logic [7:0] cur [6];
        int t0, t1;
        int per [8] = '{0, 1, 4, 16, 64, 128, 256, 512};
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        // reset values and unmapped space
        r("control one", OFS_CTRL_ONE, 32'hff, 32'h00);
        r("control two", OFS_CTRL_TWO, 32'h7f, 32'h09);
        r("day", OFS_DAY, 32'hff, 32'h01);
        r("month", OFS_MONTH, 32'hff, 32'h01);
        wr(8'h40, $random(seed), rs);
        chk("unmapped write", 32'(RESP_SLVERR), 32'(rs));
        rd(8'h44, d0, rs);
        chk("unmapped read", 32'h0, d0);
        $display("test reset and map done");
        // init order, then stop, load, calendar holds while sub counter runs
        w(OFS_CTRL_ONE, 32'h0);
        w(OFS_CTRL_TWO, 32'h0a);
        s = 8'({$random(seed)} % 60);
        m = 8'({$random(seed)} % 60);
        w(OFS_SECOND, 32'(s));
        w(OFS_MINUTE, 32'(m));
        rd(OFS_SUB_COUNT, d0, rs);
        repeat (SEC + 100) @(posedge clk);
        rd(OFS_SUB_COUNT, d1, rs);
        chk("sub counter runs", 32'h1, 32'(d0 !== d1));
        r("second held", OFS_SECOND, 32'hff, 32'(s));
        r("minute held", OFS_MINUTE, 32'hff, 32'(m));
        w(OFS_CTRL_TWO, 32'h00);
        rd(OFS_SUB_COUNT, d0, rs);
        repeat (100) @(posedge clk);
        r("sub counter halted", OFS_SUB_COUNT, 32'hff, d0);
        w(OFS_CTRL_TWO, 32'h0a);
        rd(OFS_SUB_COUNT, d0, rs);
        chk("divider cleared", 32'h1, 32'(d0[6:0] <= 7'h1));
        r("divider bit", OFS_CTRL_TWO, 32'h02, 32'h0);
        $display("test stop and load done");
        // each alarm field alone, then all six, hit and miss
        cur = '{s, m, 8'h00, 8'h00, 8'h01, 8'h01};
        for (int k = 0; k < 7; k++) begin
            for (int i = 0; i < 6; i++) begin
                w(OFS_ALM_SECOND + 8'(4 * i), (k == i || k == 6) ? {24'h0, 8'h80 | cur[i]} : 0);
            end
            w(OFS_CTRL_ONE, 32'h0);
            r("alarm match", OFS_CTRL_ONE, 32'h01, 32'h01);
            w(OFS_ALM_SECOND + 8'(4 * (k % 6)), {24'h0, 8'h80 | (cur[k % 6] + 8'h1)});
            w(OFS_CTRL_ONE, 32'h0);
            r("alarm miss", OFS_CTRL_ONE, 32'h01, 32'h00);
        end
        w(OFS_ALM_SECOND, {24'h0, 8'h80 | s});
        w(OFS_CTRL_ONE, 32'h08);
        chk("alarm request", 32'h1, 32'(alarm_request));
        w(OFS_ALM_SECOND, {24'h0, 8'h80 | (s + 8'h1)});
        w(OFS_CTRL_ONE, 32'h09);
        r("alarm flag kept", OFS_CTRL_ONE, 32'h01, 32'h01);
        w(OFS_CTRL_ONE, 32'h08);
        chk("alarm request low", 32'h0, 32'(alarm_request));
        w(OFS_CTRL_ONE, 32'h09);
        r("alarm flag stays clear", OFS_CTRL_ONE, 32'h01, 32'h00);
        $display("test alarm done");
        // a carry while the access window is open
        w(OFS_CTRL_ONE, 32'h10);
        w(OFS_CTRL_TWO, 32'h09);
        rd(OFS_SECOND, d0, rs);
        repeat (SEC + 50) @(posedge clk);
        #1;
        chk("carry request", 32'h1, 32'(carry_request));
        r("carry flag", OFS_CTRL_ONE, 32'h80, 32'h80);
        w(OFS_CTRL_ONE, 32'h90);
        r("carry flag kept", OFS_CTRL_ONE, 32'h80, 32'h80);
        w(OFS_CTRL_ONE, 32'h10);
        chk("carry request low", 32'h0, 32'(carry_request));
        $display("test carry done");
        // every periodic select code; interval checked for codes 3 to 7
        for (int p = 1; p < 8; p++) begin
            w(OFS_CTRL_TWO, 32'(p * 16 + 9));
            wait_pr(t0);
            w(OFS_CTRL_TWO, 32'(p * 16 + 9));
            if (p > 2) chk("periodic drops", 32'h0, 32'(periodic_request));
            wait_pr(t1);
            if (p > 2) chk("periodic interval", 32'(per[p] * TK), 32'(t1 - t0));
        end
        w(OFS_CTRL_TWO, 32'h89);
        chk("periodic off", 32'h0, 32'(periodic_request));
        w(OFS_CTRL_TWO, 32'h99);
        chk("periodic on", 32'h1, 32'(periodic_request));
        $display("test periodic done");
        wrap_up();
    end
endmodule
`default_nettype wire
